// File: src/tp_mau_pkg.sv
// Purpose: constants and types shared by the twisted-pair attachment control
// Assumes: hclk at 125 MHz
// Notes:   times are in their own unit, cycle counts derive from the clock rate
package tp_mau_pkg;

  localparam int CLK_MHZ = 125;

  // line timing
  localparam int EOP_NS       = 200;
  localparam int COLL_HALF_NS = 50;
  localparam int FAT_NS       = 50;
  localparam int LP_WIDTH_NS  = 100;
  localparam int POL_IDLE_NS  = 400;
  localparam int SQE_DELAY_NS = 1000;
  localparam int SQE_LEN_NS   = 1000;

  // least times round up, longest times round down
  localparam logic [4:0] EOP_CYC       = 5'((EOP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] COLL_HALF_CYC = 3'((COLL_HALF_NS * CLK_MHZ) / 1000);
  localparam logic [3:0] FAT_CYC       = 4'((FAT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] LP_WIDTH_CYC  = 4'((LP_WIDTH_NS * CLK_MHZ) / 1000);
  localparam logic [5:0] POL_IDLE_CYC  = 6'((POL_IDLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] SQE_DELAY_CYC = 8'((SQE_DELAY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] SQE_LEN_CYC   = 8'((SQE_LEN_NS * CLK_MHZ) / 1000);

  // long timers, in milliseconds
  localparam int LINK_FAIL_MS  = 100;
  localparam int LINK_PULSE_MS = 16;
  localparam int JABBER_MS     = 20;

  // register map, byte addresses
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // field positions
  localparam int CTRL_JAB_CLR   = 0;
  localparam int ST_LINK_OK     = 0;
  localparam int ST_JABBER      = 1;
  localparam int ST_POL_INV     = 2;
  localparam int ST_COLLISION   = 3;
  localparam int ST_TX_ACTIVE   = 4;
  localparam int ST_RX_ACTIVE   = 5;
  localparam int ST_AUTO_POL    = 6;
  localparam int ST_SQE         = 7;

  // synchroniser lanes
  localparam int SY_TX  = 0;
  localparam int SY_RX  = 1;
  localparam int SY_TE  = 2;
  localparam int SY_LCD = 3;
  localparam int SY_POL = 4;

  localparam logic [4:0] SYNC_RST = 5'h00;

  typedef enum logic [1:0] {SQE_IDLE, SQE_WAIT, SQE_BURST} sqe_state_t;

endpackage

// File: src/tp_medium_attachment_ctrl.sv
// Purpose: digital control of a 10 Mb/s twisted-pair attachment unit
// Assumes: line pins already digital, straps and line inputs asynchronous
// Notes:   AHB-Lite slave with zero wait states for control and status
// Notes on behaviour
// [RULE1] end of packet after 200 ns with no rising edge on transmit input
// [RULE2] terminal strap high: SQE test burst toward station after each packet
// [RULE3] terminal strap low: no SQE test, collision signalling still active
// [RULE4] floating terminal strap reads high, SQE test on by default
// [RULE5] link check disable strap high bypasses the link integrity function
// [RULE6] with link check on, receive indicator stays on while link is good
// [RULE7] simultaneous transmit and receive drive collision pair at 10 MHz
// [RULE8] polarity strap sampled high enables auto polarity, low disables
// [RULE9] with auto polarity on, polarity pin drives the polarity indicator
// [RULE10] watchdog expiry turns off line drivers and lights jabber indicator
// [RULE11] system supplies the 20 MHz reference clock; this design runs from hclk at 125 MHz instead
// [RULE12] received twisted-pair data forwarded to station as Manchester data
// [RULE13] station presents transmit frames as 10 Mb/s Manchester data
// [RULE14] link check on: no data or link pulse for 100 ms gives link fail
// [RULE15] link check on: link pulses sent while no transmission in progress
// [RULE16] low drive follows high drive, inverted in second half of fat bit
// [RULE17] jabber latches until transmit stops and software resets it
// [RULE18] transmit data repeated onto the pair with bit order and timing
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

module tp_medium_attachment_ctrl
  import tp_mau_pkg::*;
#(
  parameter int LINK_FAIL_CYC  = LINK_FAIL_MS * CLK_MHZ * 1000,
  parameter int LINK_PULSE_CYC = LINK_PULSE_MS * CLK_MHZ * 1000,
  parameter int JABBER_CYC     = JABBER_MS * CLK_MHZ * 1000
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // station side
  input  wire logic        aui_tx_in_pair,
  output logic             aui_rx_out_pair,
  output logic             aui_collision_out_pair,
  // twisted-pair side
  input  wire logic        tp_rx_in,
  output logic             tp_tx_high_drive,
  output logic             tp_tx_low_drive,
  // straps
  input  wire logic        terminal_equipment_strap,
  input  wire logic        link_check_disable_strap,
  input  wire logic        auto_polarity_strap_ind_i,
  output logic             auto_polarity_strap_ind_o,
  output logic             auto_polarity_strap_ind_oe,
  // indicators
  output logic             jabber_indicator,
  output logic             receive_activity_indicator,
  output logic             transmit_indicator,
  output logic             collision_indicator
);

  localparam logic [23:0] LINK_FAIL_LIM  = 24'(LINK_FAIL_CYC - 1);
  localparam logic [23:0] LINK_PULSE_LIM = 24'(LINK_PULSE_CYC - 1);
  localparam logic [23:0] JABBER_LIM     = 24'(JABBER_CYC - 1);

  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        tx_prev;
    logic        rx_prev;
    logic [4:0]  tx_idle;
    logic [4:0]  rx_idle;
    logic        tx_active;
    logic        rx_active;
    logic [3:0]  run_cnt;
    logic        hi_drv;
    logic        lo_drv;
    logic        jabber;
    logic [23:0] jab_cnt;
    logic        link_ok;
    logic [23:0] link_cnt;
    logic [23:0] lp_cnt;
    logic [3:0]  lp_width;
    logic        strap_done;
    logic [1:0]  strap_fill;
    logic        pol_auto;
    logic        pol_inv;
    logic [5:0]  pol_cnt;
    sqe_state_t  sqe_state;
    logic [7:0]  sqe_cnt;
    logic [2:0]  coll_div;
    logic        coll_clk;
    logic        aui_rx;
    logic        aui_coll;
    logic        rx_ind;
    logic        dph_wr;
    logic [3:0]  dph_addr;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic       rx_data;
  logic       tx_rise;
  logic       rx_rise;
  logic       eop;
  logic       link_check;
  logic       collide;
  logic       coll_req;
  logic       fat_half;
  logic       jab_clear;
  logic [31:0] status;

  always_comb begin
    state_next = state_reg;

    // two-stage synchronisers
    state_next.sync1 = {auto_polarity_strap_ind_i, link_check_disable_strap,
                        terminal_equipment_strap, tp_rx_in, aui_tx_in_pair};
    state_next.sync2 = state_reg.sync1;

    link_check = !state_reg.sync2[SY_LCD];
    rx_data    = state_reg.sync2[SY_RX] ^ state_reg.pol_inv;
    tx_rise    = state_reg.sync2[SY_TX] && !state_reg.tx_prev;
    rx_rise    = rx_data && !state_reg.rx_prev;
    state_next.tx_prev = state_reg.sync2[SY_TX];
    state_next.rx_prev = rx_data;

    // polarity strap caught once the synchronisers hold the pin after reset release
    state_next.strap_fill = {state_reg.strap_fill[0], 1'b1};
    if (!state_reg.strap_done && state_reg.strap_fill[1]) begin
      state_next.strap_done = 1'b1;
      state_next.pol_auto   = state_reg.sync2[SY_POL]; // [RULE8]
    end

    // transmit activity and end of packet
    eop = 1'b0;
    if (tx_rise) begin
      state_next.tx_active = 1'b1;
      state_next.tx_idle   = 5'h00;
    end else if (state_reg.tx_active) begin
      if (state_reg.tx_idle == EOP_CYC - 5'h01) begin
        state_next.tx_active = 1'b0; // [RULE1]
        eop = 1'b1;
      end else begin
        state_next.tx_idle = state_reg.tx_idle + 5'h01;
      end
    end

    // link integrity
    if (!link_check) begin
      state_next.link_ok  = 1'b1; // [RULE5]
      state_next.link_cnt = 24'h000000;
    end else if (rx_rise) begin
      state_next.link_ok  = 1'b1;
      state_next.link_cnt = 24'h000000;
    end else if (state_reg.link_cnt == LINK_FAIL_LIM) begin
      state_next.link_ok = 1'b0; // [RULE14]
    end else begin
      state_next.link_cnt = state_reg.link_cnt + 24'h000001;
    end

    // receive activity, only over a usable link
    if (rx_rise && state_reg.link_ok) begin
      state_next.rx_active = 1'b1;
      state_next.rx_idle   = 5'h00;
    end else if (state_reg.rx_active) begin
      if (state_reg.rx_idle == EOP_CYC - 5'h01 || !state_reg.link_ok) begin
        state_next.rx_active = 1'b0;
      end else begin
        state_next.rx_idle = state_reg.rx_idle + 5'h01;
      end
    end

    // polarity: a pair left high while idle is reversed
    if (!state_reg.pol_auto || !state_reg.strap_done) begin
      state_next.pol_inv = 1'b0;
      state_next.pol_cnt = 6'h00;
    end else if (state_reg.rx_active || !rx_data) begin
      state_next.pol_cnt = 6'h00;
    end else if (state_reg.pol_cnt == POL_IDLE_CYC - 6'h01) begin
      state_next.pol_inv = !state_reg.pol_inv; // [RULE8]
      state_next.pol_cnt = 6'h00;
    end else begin
      state_next.pol_cnt = state_reg.pol_cnt + 6'h01;
    end

    // jabber watchdog
    jab_clear = state_reg.dph_wr && state_reg.dph_addr == CTRL_OFS &&
                hwdata[CTRL_JAB_CLR];
    if (state_reg.tx_active && !state_reg.jabber) begin
      if (state_reg.jab_cnt == JABBER_LIM) begin
        state_next.jabber = 1'b1; // [RULE10]
      end else begin
        state_next.jab_cnt = state_reg.jab_cnt + 24'h000001;
      end
    end else if (!state_reg.tx_active) begin
      state_next.jab_cnt = 24'h000000;
      if (jab_clear) begin
        state_next.jabber = 1'b0; // [RULE17]
      end
    end

    // link pulses while the transmitter is quiet
    if (state_reg.lp_width != 4'h0) begin
      state_next.lp_width = state_reg.lp_width - 4'h1;
    end
    if (!link_check || state_reg.tx_active || state_reg.jabber) begin
      state_next.lp_cnt = 24'h000000;
    end else if (state_reg.lp_cnt == LINK_PULSE_LIM) begin
      state_next.lp_cnt   = 24'h000000;
      state_next.lp_width = LP_WIDTH_CYC; // [RULE15]
    end else begin
      state_next.lp_cnt = state_reg.lp_cnt + 24'h000001;
    end

    // run length of the transmit level for the fat-bit predistortion
    if (state_reg.sync2[SY_TX] != state_reg.tx_prev) begin
      state_next.run_cnt = 4'h1;
    end else if (state_reg.run_cnt != 4'hf) begin
      state_next.run_cnt = state_reg.run_cnt + 4'h1;
    end

    // second half of a widened cell only: the run count is stale on the first
    // cycle of a new level, so a level change never counts as fat
    fat_half = state_reg.sync2[SY_TX] == state_reg.tx_prev &&
               state_reg.run_cnt >= FAT_CYC;

    // line drivers
    if (state_reg.jabber) begin
      state_next.hi_drv = 1'b0; // [RULE10]
      state_next.lo_drv = 1'b0;
    end else if (state_reg.tx_active) begin
      state_next.hi_drv = state_reg.sync2[SY_TX]; // [RULE18]
      state_next.lo_drv = state_reg.sync2[SY_TX] ^ fat_half; // [RULE16]
    end else begin
      state_next.hi_drv = state_reg.lp_width != 4'h0;
      state_next.lo_drv = state_reg.lp_width != 4'h0; // [RULE16]
    end

    // sqe test after each packet
    unique case (state_reg.sqe_state)
      SQE_IDLE: begin
        if (eop && state_reg.sync2[SY_TE] && !state_reg.jabber) begin
          state_next.sqe_state = SQE_WAIT; // [RULE2] [RULE4]
          state_next.sqe_cnt   = 8'h00;
        end
      end
      SQE_WAIT: begin
        if (state_reg.sqe_cnt == SQE_DELAY_CYC - 8'h01) begin
          state_next.sqe_state = SQE_BURST;
          state_next.sqe_cnt   = 8'h00;
        end else begin
          state_next.sqe_cnt = state_reg.sqe_cnt + 8'h01;
        end
      end
      SQE_BURST: begin
        if (state_reg.sqe_cnt == SQE_LEN_CYC - 8'h01) begin
          state_next.sqe_state = SQE_IDLE;
        end else begin
          state_next.sqe_cnt = state_reg.sqe_cnt + 8'h01;
        end
      end
    endcase

    // 10 MHz collision signal, independent of the terminal strap
    collide  = state_reg.tx_active && state_reg.rx_active; // [RULE3]
    coll_req = collide || state_reg.sqe_state == SQE_BURST;

    // divider waits high while quiet, so every burst opens with a full half period
    if (!coll_req) begin
      state_next.coll_div = 3'h0;
      state_next.coll_clk = 1'b1;
    end else if (state_reg.coll_div == COLL_HALF_CYC - 3'h1) begin
      state_next.coll_div = 3'h0;
      state_next.coll_clk = !state_reg.coll_clk;
    end else begin
      state_next.coll_div = state_reg.coll_div + 3'h1;
    end
    state_next.aui_coll = coll_req && state_reg.coll_clk; // [RULE7]

    // receive path to the station
    state_next.aui_rx = state_reg.rx_active && rx_data; // [RULE12]
    state_next.rx_ind = state_reg.rx_active || (link_check && state_reg.link_ok); // [RULE6]

    // bus slave
    // status word, read only
    status = 32'h00000000;
    status[ST_LINK_OK]   = state_reg.link_ok;
    status[ST_JABBER]    = state_reg.jabber;
    status[ST_POL_INV]   = state_reg.pol_inv;
    status[ST_COLLISION] = collide;
    status[ST_TX_ACTIVE] = state_reg.tx_active;
    status[ST_RX_ACTIVE] = state_reg.rx_active;
    status[ST_AUTO_POL]  = state_reg.pol_auto;
    status[ST_SQE]       = state_reg.sqe_state != SQE_IDLE;
    // address phase captured for the following data phase
    state_next.dph_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      state_next.dph_wr   = hwrite;
      state_next.dph_addr = haddr[3:0];
      unique case (haddr[3:0])
        STATUS_OFS: state_next.rdata = hwrite ? 32'h00000000 : status;
        default:    state_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg           <= '0;
      state_reg.sync1     <= SYNC_RST;
      state_reg.sync2     <= SYNC_RST;
      state_reg.sqe_state <= SQE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register, bus always ready
  assign hreadyout                  = 1'b1;
  assign hresp                      = 1'b0;
  assign hrdata                     = state_reg.rdata;
  assign aui_rx_out_pair            = state_reg.aui_rx;
  assign aui_collision_out_pair     = state_reg.aui_coll;
  assign tp_tx_high_drive           = state_reg.hi_drv;
  assign tp_tx_low_drive            = state_reg.lo_drv;
  assign auto_polarity_strap_ind_o  = state_reg.pol_inv;
  assign auto_polarity_strap_ind_oe = state_reg.pol_auto; // [RULE9]
  assign jabber_indicator           = state_reg.jabber; // [RULE10]
  assign receive_activity_indicator = state_reg.rx_ind;
  assign transmit_indicator         = state_reg.tx_active;
  assign collision_indicator        = state_reg.aui_coll;

endmodule

// File: verification/tp_far_end.sv
// Purpose: far-end transceiver sending Manchester frames on the receive pair
// Assumes: bench clock, half bit of 6 cycles
// Notes:   quiet pair rests low, flip models a reversed pair
`timescale 1ns/1ps
module tp_far_end (
  // clock
  input  wire logic hclk,
  // control
  input  wire logic send,
  input  wire logic flip,
  // line
  output logic      tp_rx
);
  logic [2:0] ph = 3'h0;
  logic       lv = 1'b0;
  always @(posedge hclk) begin
    ph <= (send && ph != 3'h5) ? ph + 3'h1 : 3'h0;
    if (!send) lv <= 1'b0;
    else if (ph == 3'h5) lv <= !lv;
  end
  assign tp_rx = lv ^ flip;
endmodule

// File: verification/tp_mau_monitor.sv
// Purpose: port-level checks of the twisted-pair attachment control
// Assumes: one clock domain, hresetn asynchronous and active low
// Notes:   link fail count handed on from the instance
`timescale 1ns/1ps
module tp_mau_monitor #(
  parameter int LINK_FAIL_CYC = 2000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line side
  input wire logic aui_tx_in_pair,
  input wire logic aui_collision_out_pair,
  input wire logic tp_rx_in,
  input wire logic tp_tx_high_drive,
  input wire logic tp_tx_low_drive,
  // straps and indicators
  input wire logic link_check_disable_strap,
  input wire logic auto_polarity_strap_ind_o,
  input wire logic auto_polarity_strap_ind_oe,
  input wire logic jabber_indicator,
  input wire logic receive_activity_indicator,
  input wire logic transmit_indicator
);
  logic rx_q;
  int   quiet;
  // cycles with no receive edge while link check is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_q  <= 1'b0;
      quiet <= 0;
    end else begin
      rx_q <= tp_rx_in;
      if (tp_rx_in != rx_q || link_check_disable_strap) quiet <= 0;
      else if (quiet < LINK_FAIL_CYC + 16) quiet <= quiet + 1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  jab_drv_off_a: assert property (jabber_indicator |->
    ##2 (!tp_tx_high_drive && !tp_tx_low_drive)) else $error("drives on during jabber");
  tx_follow_a: assert property (transmit_indicator && $past(transmit_indicator, 2) &&
    !jabber_indicator && !$past(jabber_indicator, 2) |->
    tp_tx_high_drive == $past(aui_tx_in_pair, 3)) else $error("pair drive not following");
  lo_follow_a: assert property (tp_tx_low_drive != tp_tx_high_drive |->
    tp_tx_high_drive == $past(tp_tx_high_drive, 2)) else $error("low drive split off");
  coll_half_a: assert property ($rose(aui_collision_out_pair) |->
    ##6 !aui_collision_out_pair) else $error("collision half period wrong");
  jab_latch_a: assert property ($fell(jabber_indicator) |->
    !$past(transmit_indicator)) else $error("jabber cleared during transmit");
  pol_oe_a: assert property (auto_polarity_strap_ind_o |->
    auto_polarity_strap_ind_oe) else $error("polarity shown while pin not driven");
  rx_ind_a: assert property ($rose(tp_rx_in) && !link_check_disable_strap &&
    !auto_polarity_strap_ind_o |-> ##[1:6] receive_activity_indicator)
    else $error("receive indicator missing");
  link_fail_a: assert property (quiet == LINK_FAIL_CYC + 16 |->
    !receive_activity_indicator) else $error("link fail not entered");
endmodule

bind tp_medium_attachment_ctrl tp_mau_monitor #(.LINK_FAIL_CYC(LINK_FAIL_CYC)) i_tp_mau_monitor (
  .hclk, .hresetn, .aui_tx_in_pair, .aui_collision_out_pair, .tp_rx_in, .tp_tx_high_drive,
  .tp_tx_low_drive, .link_check_disable_strap, .auto_polarity_strap_ind_o,
  .auto_polarity_strap_ind_oe, .jabber_indicator, .receive_activity_indicator,
  .transmit_indicator);

// File: verification/tp_medium_attachment_ctrl_tb_top.sv
// Purpose: self-checking bench for the twisted-pair attachment control
// Assumes: bench acts as station, far-end model on the receive pair
// Notes:   long timers shortened through parameters
`timescale 1ns/1ps
module tp_medium_attachment_ctrl_tb_top;
  import tp_mau_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx = 1'b0;
  logic        te = 1'b1;
  logic        lcd = 1'b0, pol_s = 1'b1, send = 1'b0, flip = 1'b0;
  logic        hready, hresp, rx_line, aui_rx, coll, hi, lo, pol_o, pol_oe, jab, rxi, txi, cind;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  int          errors = 0, checks = 0, cyc = 0, c_coll = 0, c_rx = 0, c_fat = 0, c_cind = 0;
  wire         pol_pin = pol_oe ? pol_o : pol_s;

  tp_medium_attachment_ctrl #(.LINK_FAIL_CYC(2000), .LINK_PULSE_CYC(500), .JABBER_CYC(1000))
    i_tp_medium_attachment_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
    .aui_tx_in_pair(tx), .aui_rx_out_pair(aui_rx), .aui_collision_out_pair(coll),
    .tp_rx_in(rx_line), .tp_tx_high_drive(hi), .tp_tx_low_drive(lo),
    .terminal_equipment_strap(te), .link_check_disable_strap(lcd),
    .auto_polarity_strap_ind_i(pol_pin), .auto_polarity_strap_ind_o(pol_o),
    .auto_polarity_strap_ind_oe(pol_oe), .jabber_indicator(jab),
    .receive_activity_indicator(rxi), .transmit_indicator(txi), .collision_indicator(cind));
  tp_far_end i_tp_far_end (.hclk, .send, .flip, .tp_rx(rx_line));

  initial begin
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    c_coll <= c_coll + (coll === 1'b1);
    c_cind <= c_cind + (cind !== coll);
    c_rx <= c_rx + (aui_rx === 1'b1);
    c_fat <= c_fat + (lo !== hi && txi === 1'b1);
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic do_reset(input logic p);
    pol_s <= p;
    hresetn <= 1'b0;
    cycles(10);
    hresetn <= 1'b1;
    cycles(6);
  endtask
  // station frame, half bit 6 cycles, one widened half bit in the middle
  task automatic station(input int n);
    for (int i = 0; i < n; i++) begin
      tx <= ~tx;
      cycles(i == n / 2 ? 12 : 6);
    end
    tx <= 1'b0;
  endtask
  task automatic pulses(input int n, output int np);
    logic hp;
    np = 0;
    hp = 1'b1;
    repeat (n) begin
      @(posedge hclk);
      if (hi === 1'b1 && !hp) np++;
      hp = hi;
    end
  endtask

  task automatic t_pol();
    check(pol_oe, 1'b1);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_AUTO_POL], 1'b1);
    flip <= 1'b1;
    cycles(80);
    check(pol_pin, 1'b1);
  endtask
  task automatic t_sqe();
    int n;
    station(20);
    check(txi, 1'b1);
    n = 0;
    while (coll !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    check(n >= EOP_CYC - 12 + SQE_DELAY_CYC, 1'b1);
    check(n <= EOP_CYC + SQE_DELAY_CYC, 1'b1);
    check(txi, 1'b0);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_SQE], 1'b1);
    check(c_fat > 0, 1'b1);
    cycles(200);
  endtask
  task automatic t_nosqe();
    int c0;
    te <= 1'b0;
    cycles(4);
    c0 = c_coll;
    station(20);
    cycles(300);
    check(c_coll - c0, 0);
    c0 = c_coll;
    send <= 1'b1;
    station(40);
    check(rxi, 1'b1);
    check(c_coll > c0, 1'b1);
    check(c_cind, 0);
    check(c_rx > 0, 1'b1);
    send <= 1'b0;
    cycles(60);
  endtask
  task automatic t_jab();
    station(200);
    check(jab, 1'b1);
    check(hi, 1'b0);
    bus(1'b1, 32'(CTRL_OFS), 32'h1 << CTRL_JAB_CLR);
    cycles(40);
    bus(1'b1, 32'hc, 32'h1);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_JABBER], 1'b1);
    bus(1'b1, 32'(CTRL_OFS), 32'h1 << CTRL_JAB_CLR);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_JABBER], 1'b0);
  endtask
  task automatic t_link();
    int np;
    pulses(1900, np);
    check(np >= 3 && np <= 4, 1'b1);
    check(rxi, 1'b0);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_LINK_OK], 1'b0);
    lcd <= 1'b1;
    cycles(4);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_LINK_OK], 1'b1);
    pulses(1100, np);
    check(np, 0);
    lcd <= 1'b0;
  endtask

  initial begin
    do_reset(1'b1);
    t_pol();
    t_sqe();
    t_nosqe();
    t_jab();
    t_link();
    do_reset(1'b0);
    check(pol_oe, 1'b0);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    check(q[ST_AUTO_POL], 1'b0);
    conclude();
  end
endmodule
